// >>> design/ext_irq_trigger_filter.v
// Trigger-mode decode, noise filter and pending logic for inputs 16 to 23
// Alternate filter clock is sampled by clk: keep it below half clk rate.
// Level inputs set their pending bit again each cycle the level holds,
// so a clear only sticks once the pin has left the active level.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.vh"

module ext_irq_trigger_filter #(
    parameter NUM_IN = 8
) (
    // Clock and reset
    input  wire                clk,
    input  wire                arst_n,
    // Avalon-MM slave
    input  wire [31:0]         address,
    input  wire                read,
    input  wire                write,
    input  wire [31:0]         writedata,
    input  wire [3:0]          byteenable,
    output reg  [31:0]         readdata,
    output wire                waitrequest,
    // Request pins and filter clock sources
    input  wire [NUM_IN-1:0]   externalRequestPin,
    input  wire                bootModePins,
    input  wire                externalClockInput,
    input  wire                oscillatorClock,
    // Interrupt
    output wire                irq
);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    reg         ack_q;
    wire        ack_d;
    wire        req;
    wire        wrAcc;
    wire        rdTake;

    // One wait cycle, so a read is always served from a register
    assign req         = read | write;
    assign ack_d       = req & ~ack_q;
    assign waitrequest = req & ~ack_q;
    assign wrAcc       = write & ack_q;
    assign rdTake      = read & ~ack_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [31:0]        trig_q;
    reg  [31:0]        filtLo_q;
    reg  [31:0]        filtHi_q;
    reg  [NUM_IN-1:0]  mask_q;
    reg  [NUM_IN-1:0]  pend_q;
    wire [NUM_IN-1:0]  pend_d;
    wire [NUM_IN-1:0]  hit;
    wire [NUM_IN-1:0]  pendClr;
    wire [63:0]        filtAll;

    assign filtAll = {filtHi_q, filtLo_q};

    // Address decode; spares need no select, their writes are dropped
    wire               selTrig;
    wire               selFiltLo;
    wire               selFiltHi;
    wire               selMask;
    wire               selPend;

    assign selTrig   = (address == `TRIG_ADDR);
    assign selFiltLo = (address == `FILT_LO_ADDR);
    assign selFiltHi = (address == `FILT_HI_ADDR);
    assign selMask   = (address == `MASK_ADDR);
    assign selPend   = (address == `PEND_ADDR);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= `TRIG_RST;
        end else if (wrAcc && selTrig) begin
            trig_q <= merge(trig_q, writedata, byteenable);
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filtLo_q <= `FILT_RST;
        end else if (wrAcc && selFiltLo) begin
            filtLo_q <= merge(filtLo_q, writedata, byteenable);
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filtHi_q <= `FILT_RST;
        end else if (wrAcc && selFiltHi) begin
            filtHi_q <= merge(filtHi_q, writedata, byteenable);
        end
    end

    // Mask and pending hold eight bits, so only lane 0 matters
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= `MASK_RST;
        end else if (wrAcc && selMask && byteenable[0]) begin
            mask_q <= writedata[NUM_IN-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    assign pendClr = (wrAcc && selPend && byteenable[0])
                   ? writedata[NUM_IN-1:0] : {NUM_IN{1'b0}};
    assign pend_d  = (pend_q & ~pendClr) | hit;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= `PEND_RST;
        end else begin
            pend_q <= pend_d;
        end
    end

    assign irq = |(pend_q & ~mask_q);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= 32'h0000_0000;
        end else if (rdTake) begin
            case (address)
                `TRIG_ADDR: begin
                    readdata <= trig_q;
                end
                `FILT_LO_ADDR: begin
                    readdata <= filtLo_q;
                end
                `FILT_HI_ADDR: begin
                    readdata <= filtHi_q;
                end
                `SPARE_A_ADDR: begin
                    readdata <= `SPARE_RST;
                end
                `SPARE_B_ADDR: begin
                    readdata <= `SPARE_RST;
                end
                `MASK_ADDR: begin
                    readdata <= {{(32-NUM_IN){1'b0}}, mask_q};
                end
                `PEND_ADDR: begin
                    readdata <= {{(32-NUM_IN){1'b0}}, pend_q};
                end
                default: begin
                    readdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alternate filter clock, sampled as a level in the bus clock domain

    reg  altPrev_q;
    wire altLvl;
    wire altTick;

    // Source picked by the boot straps; a tick per rising edge seen
    assign altLvl  = bootModePins ? oscillatorClock : externalClockInput;
    assign altTick = altLvl & ~altPrev_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            altPrev_q <= 1'b0;
        end else begin
            altPrev_q <= altLvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-input filter and trigger detection

    genvar i;
    generate
        for (i = 0; i < NUM_IN; i = i + 1) begin : g_in
            wire [`TRIG_W-1:0] mode;
            wire               fen;
            wire [`FILT_W-1:0] width;
            wire               fsel;
            wire               tick;
            wire               lvl;
            wire               rise;
            wire               fall;
            reg  [`FILT_W-1:0] cnt_q;
            reg                flt_q;
            reg                prev_q;
            reg                det;
            reg  [`FILT_W-1:0] cnt_d;
            reg                flt_d;

            assign mode  = trig_q[i*`TRIG_STRIDE +: `TRIG_W];
            assign fen   = trig_q[i*`TRIG_STRIDE + `FEN_BIT];
            assign width = filtAll[i*`FILT_STRIDE +: `FILT_W];
            assign fsel  = filtAll[i*`FILT_STRIDE + `FSEL_BIT];
            assign tick  = fsel ? altTick : 1'b1;

            // Candidate level must differ for width+1 ticks to be taken;
            // any return to the old level restarts the count
            always @* begin
                cnt_d = cnt_q;
                flt_d = flt_q;
                if (!fen || externalRequestPin[i] == flt_q) begin
                    cnt_d = {`FILT_W{1'b0}};
                    flt_d = externalRequestPin[i];
                end else if (tick) begin
                    if (cnt_q == width) begin
                        cnt_d = {`FILT_W{1'b0}};
                        flt_d = externalRequestPin[i];
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end

            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_q <= {`FILT_W{1'b0}};
                    flt_q <= `LVL_IDLE;
                end else begin
                    cnt_q <= cnt_d;
                    flt_q <= flt_d;
                end
            end

            assign lvl  = fen ? flt_q : externalRequestPin[i];
            assign rise = lvl & ~prev_q;
            assign fall = ~lvl & prev_q;

            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    prev_q <= `LVL_IDLE;
                end else begin
                    prev_q <= lvl;
                end
            end

            always @* begin
                case (mode[2:1])
                    `MODE_LEVEL: begin
                        det = mode[0] ? lvl : ~lvl;
                    end
                    `MODE_FALL: begin
                        det = fall;
                    end
                    `MODE_RISE: begin
                        det = rise;
                    end
                    `MODE_BOTH: begin
                        det = rise | fall;
                    end
                    default: begin
                        det = 1'b0;
                    end
                endcase
            end

            assign hit[i] = det;
        end
    endgenerate

endmodule
`default_nettype wire

// >>> design/ext_irq_map.vh
// Register map, field layout and constants of the external trigger block
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH

// Byte addresses
`define TRIG_ADDR      32'h5600_0090
`define SPARE_A_ADDR   32'h5600_0094
`define SPARE_B_ADDR   32'h5600_0098
`define FILT_LO_ADDR   32'h5600_009c
`define FILT_HI_ADDR   32'h4c60_00a0
`define MASK_ADDR      32'h5600_00a4
`define PEND_ADDR      32'h5600_00a8

// Reset values
`define TRIG_RST       32'h0000_0000
`define FILT_RST       32'h0000_0000
`define SPARE_RST      32'h0000_0000
`define MASK_RST       8'hff
`define PEND_RST       8'h00
`define LVL_IDLE       1'b1

// Trigger register: one nibble per input
`define TRIG_STRIDE    4
`define TRIG_W         3
`define FEN_BIT        3

// Filter registers: one byte per input, two words
`define FILT_STRIDE    8
`define FILT_W         7
`define FSEL_BIT       7

// Trigger mode, upper two bits of the field
`define MODE_LEVEL     2'h0
`define MODE_FALL      2'h1
`define MODE_RISE      2'h2
`define MODE_BOTH      2'h3

// Shortest valid level at the pin, and the bus clock period
`define MIN_LEVEL_NS   40
`define CLK_PERIOD_NS  10

`endif

// >>> verification/ext_pin_model.sv
// Board-side model of the request pins and alternate filter clocks
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model (
    // Clock
    input  wire logic       clk,
    // Board pins
    output var  logic [7:0] pins,
    output var  logic       external_clock_input,
    output var  logic       oscClk,
    output var  logic       bootSel
);
    initial begin
        pins = 8'hff;
        external_clock_input = 1'b0;
        oscClk = 1'b0;
        bootSel = 1'b0;
    end
    // Never shorter than four cycles, the shortest valid level
    task automatic drive(input logic [7:0] v, input int n);
        pins <= v;
        repeat (n < 4 ? 4 : n) @(posedge clk);
    endtask
    task automatic ticks(input int n, input logic osc);
        repeat (n) begin
            if (osc) oscClk <= 1'b1;
            else external_clock_input <= 1'b1;
            repeat (2) @(posedge clk);
            oscClk <= 1'b0;
            external_clock_input <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic pick(input logic s);
        bootSel <= s;
    endtask
endmodule
`default_nettype wire

// >>> verification/ext_irq_trigger_filter_properties.sv
// Port checker of the trigger and filter block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.vh"
module ext_irq_trigger_filter_properties #(
    parameter NUM_IN = 8
) (
    // Clock, reset, bus
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [31:0]       address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [31:0]       writedata,
    input wire logic [31:0]       readdata,
    input wire logic              waitrequest,
    // Pins and interrupt
    input wire logic [NUM_IN-1:0] externalRequestPin,
    input wire logic              irq
);
    logic [31:0] trigQ;
    logic [31:0] filtQ;
    logic [7:0]  maskQ;
    // Shadows assume full-word writes, as the bench always makes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trigQ <= 32'h0000_0000;
            filtQ <= 32'h0000_0000;
            maskQ <= 8'hff;
        end else if (write && !waitrequest) begin
            if (address == `TRIG_ADDR) trigQ <= writedata;
            if (address == `FILT_LO_ADDR) filtQ <= writedata;
            if (address == `MASK_ADDR) maskQ <= writedata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence rdDone(a);
        read && !waitrequest && address == a;
    endsequence
    a_trig_readback: assert property (rdDone(`TRIG_ADDR) |->
        readdata == trigQ) else $error("trigger readback wrong");
    a_filt_readback: assert property (rdDone(`FILT_LO_ADDR) |->
        readdata == filtQ) else $error("filter readback wrong");
    a_spare_zero: assert property (rdDone(`SPARE_A_ADDR) |->
        readdata == 32'h0000_0000) else $error("spare not zero");
    a_fall_raises_irq: assert property (trigQ[11:8] == 4'h2 &&
        !maskQ[2] && $fell(externalRequestPin[2]) |-> ##[1:2] irq)
        else $error("falling edge missed");
    a_low_level_irq: assert property (trigQ[3:0] == 4'h0 &&
        !maskQ[0] && !externalRequestPin[0] |-> ##[1:2] irq)
        else $error("low level missed");
    a_filter_holds_off: assert property (trigQ[3:0] == 4'ha &&
        filtQ[7:0] > 8'h01 && filtQ[7:0] < 8'h80 && maskQ == 8'hfe &&
        !irq && $fell(externalRequestPin[0]) |=> !irq)
        else $error("filter passed a short change");
    a_irq_sticky: assert property (irq && !write |=> irq)
        else $error("interrupt dropped without a write");
    a_reset_quiet: assert property ($rose(arst_n) |-> !irq)
        else $error("interrupt out of reset");
    a_wait_once: assert property ((read || write) && waitrequest |=>
        !waitrequest) else $error("more than one wait cycle");
endmodule
bind ext_irq_trigger_filter ext_irq_trigger_filter_properties #(
    .NUM_IN(NUM_IN)) ext_irq_trigger_filter_properties_inst (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .externalRequestPin(externalRequestPin),
    .irq(irq));
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the trigger and filter block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.vh"
module testbench;
    logic clk, arst_n, read, write, waitrequest, irq, external_clock_input, oscClk, boot;
    logic [31:0] address, writedata, readdata;
    logic [3:0]  byteenable;
    logic [7:0]  pins;
    int          errors, check_count, cycles;
    ext_irq_trigger_filter ext_irq_trigger_filter_inst (.clk(clk),
        .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .externalRequestPin(pins), .bootModePins(boot),
        .externalClockInput(external_clock_input), .oscillatorClock(oscClk), .irq(irq));
    ext_pin_model ext_pin_model_inst (.clk(clk), .pins(pins),
        .external_clock_input(external_clock_input), .oscClk(oscClk), .bootSel(boot));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic
        [31:0] d, output logic [31:0] r);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rc(`TRIG_ADDR, 32'h0000_0000);
        rc(`FILT_LO_ADDR, 32'h0000_0000);
        rc(`MASK_ADDR, 32'h0000_00ff);
        wr(`TRIG_ADDR, 32'hfedc_ba98);
        rc(`TRIG_ADDR, 32'hfedc_ba98);
        wr(`FILT_LO_ADDR, 32'h8180_7f01);
        rc(`FILT_LO_ADDR, 32'h8180_7f01);
        wr(`FILT_HI_ADDR, 32'h0102_fe7f);
        rc(`FILT_HI_ADDR, 32'h0102_fe7f);
        wr(`SPARE_A_ADDR, 32'hffff_ffff);
        rc(`SPARE_A_ADDR, 32'h0000_0000);
        rc(32'h5600_0080, 32'h0000_0000);
        $display("registers test done");
    endtask
    // Input k runs trigger code k, so all eight codes at once
    task automatic t_modes;
        wr(`MASK_ADDR, 32'h0000_0000);
        wr(`FILT_LO_ADDR, 32'h0000_0000);
        wr(`TRIG_ADDR, 32'h7654_3210);
        ext_pin_model_inst.drive(8'hff, 4);
        wr(`PEND_ADDR, 32'h0000_00ff);
        ext_pin_model_inst.drive(8'h00, 4);
        rc(`PEND_ADDR, 32'h0000_00cf);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`PEND_ADDR, 32'h0000_00ff);
        ext_pin_model_inst.drive(8'hff, 4);
        rc(`PEND_ADDR, 32'h0000_00f3);
        wr(`MASK_ADDR, 32'h0000_00ff);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`TRIG_ADDR, 32'h4444_4444);
        wr(`PEND_ADDR, 32'h0000_00ff);
        rc(`PEND_ADDR, 32'h0000_0000);
        $display("modes test done");
    endtask
    // Width 5 needs six stable ticks; a five-cycle pulse is dropped
    task automatic t_filter;
        wr(`MASK_ADDR, 32'h0000_00fe);
        wr(`TRIG_ADDR, 32'h0000_000a);
        wr(`FILT_LO_ADDR, 32'h0000_0005);
        ext_pin_model_inst.drive(8'hff, 8);
        wr(`PEND_ADDR, 32'h0000_00ff);
        ext_pin_model_inst.drive(8'hfe, 5);
        ext_pin_model_inst.drive(8'hff, 8);
        rc(`PEND_ADDR, 32'h0000_0000);
        ext_pin_model_inst.drive(8'hfe, 7);
        rc(`PEND_ADDR, 32'h0000_0001);
        wr(`FILT_LO_ADDR, 32'h0000_0085);
        ext_pin_model_inst.drive(8'hff, 4);
        ext_pin_model_inst.ticks(8, 1'b0);
        wr(`PEND_ADDR, 32'h0000_00ff);
        ext_pin_model_inst.drive(8'hfe, 20);
        rc(`PEND_ADDR, 32'h0000_0000);
        ext_pin_model_inst.ticks(6, 1'b0);
        rc(`PEND_ADDR, 32'h0000_0001);
        ext_pin_model_inst.pick(1'b1);
        ext_pin_model_inst.drive(8'hff, 4);
        ext_pin_model_inst.ticks(8, 1'b1);
        wr(`PEND_ADDR, 32'h0000_00ff);
        ext_pin_model_inst.drive(8'hfe, 4);
        ext_pin_model_inst.ticks(8, 1'b0);
        rc(`PEND_ADDR, 32'h0000_0000);
        ext_pin_model_inst.ticks(6, 1'b1);
        rc(`PEND_ADDR, 32'h0000_0001);
        $display("filter test done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test;
        end
    end
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 32'h0000_0000;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_modes;
        t_filter;
        finish_test;
    end
endmodule
`default_nettype wire
